//--- include/guard_pkg.sv
// How it works
// - read outside user map still answers, data zero
// - write outside user map is dropped, answer carries zero
// - write to read-only register is dropped, answer carries current contents
// - factory OTP blocks checked by per-16-byte 4-bit CRC
// - user OTP regions zero and one checked by per-block 4-bit CRC
// - CRC polynomial x^4+x^3+1, seed all zero
// - bits enter MSB first, bytes in ascending address order
// - region three checked against CRC nibble in its lock-and-CRC register
// - mirror registers writable only while end_of_init is clear
// - after end_of_init, continuous CRC over R/W and region three, lock write excluded
// - logic held in reset while any supply is under threshold
// - buffer supply dip during capacitor test sets buffer_cap_fault in status word one
// - capacitor test runs in step with protocol transmissions
// - bus, buffer, digital and analog supply undervoltage trigger abort handling
// - DSI3 command mode: undervoltage in reception discards command, no answer
// - DSI3 command mode: undervoltage in response cuts it, no resend
// - DSI3 periodic: undervoltage in reception drops period answer, flushes diagnostic
// - DSI3 periodic: undervoltage in response ends it, flushes diagnostic command
// - undervoltage in diagnostic response ends it, diagnostic decode restarts
// - after recovery, decoding and periodic answers resume
// - PSI5: undervoltage ends present response, answers resume on recovery
// - lock-and-CRC register: lock bit 7, block id 6:4, CRC 3:0
package guard_pkg;
    // address regions of the register map
    localparam logic [7:0] RW_LO = 8'h10;
    localparam logic [7:0] RW_HI = 8'h3f;
    localparam logic [7:0] UF2_LO = 8'h40;
    localparam logic [7:0] UF2_HI = 8'h5f;
    localparam logic [7:0] UF2_MID = 8'h50;
    localparam logic [7:0] UF0_LO = 8'h60;
    localparam logic [7:0] UF1_HI = 8'h7f;
    localparam logic [7:0] FAC_LO = 8'ha0;
    localparam logic [7:0] LOCK_WR_ADDR = 8'h10;
    localparam logic [7:0] REGION3_LOCK_CRC_ADDR = 8'h5f;
    localparam logic [7:0] STATUS_WORD_ONE_ADDR = 8'h02;
    localparam logic [3:0] BLOCK_LAST = 4'hf;
    // lock-and-CRC field layout
    localparam int LOCK_BIT = 7;
    localparam int CRC_MSB = 3;
    // status word one bit positions
    localparam int ST_BUF_CAP = 0;
    localparam int ST_OTP_CRC = 1;
    localparam int ST_ARR_CRC = 2;
    // crc constants
    localparam logic [3:0] CRC_SEED = 4'h0;
    localparam logic [3:0] CRC_POLY = 4'h9;
    // reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ZERO_DATA = 8'h00;
    localparam logic [3:0] UV_NONE = 4'h0;
    // capacitor test window length in cycles
    localparam logic [3:0] CAP_TEST_CYC = 4'h8;

    typedef enum logic [1:0] {
        MODE_CRM = 2'h0,
        MODE_PDCM = 2'h1,
        MODE_PSI5 = 2'h2
    } proto_mode_t;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_cmd_t;

    typedef struct packed {
        logic rx_active;
        logic tx_active;
        logic bdm_tx_active;
        logic tx_start;
    } link_phase_t;
endpackage

//--- verilog/crc4_unit.sv
`timescale 1ns/1ps
`default_nettype none
module crc4_unit
    import guard_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clear_i,
    input wire logic en_i,
    input wire logic [7:0] byte_i,
    output logic [3:0] crc_o
);
    // one byte per cycle, msb first; clear restarts from seed with this byte
    function automatic logic [3:0] crc_byte(input logic [3:0] c_in, input logic [7:0] b);
        logic [3:0] c;
        logic fb;
        c = c_in;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[3] ^ b[i];
            c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // crc state register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crc_o <= CRC_SEED;
        end else if (en_i) begin
            crc_o <= crc_byte(clear_i ? CRC_SEED : crc_o, byte_i);
        end else if (clear_i) begin
            crc_o <= CRC_SEED;
        end
    end
endmodule
`default_nettype wire

//--- verilog/supply_guard.sv
`timescale 1ns/1ps
`default_nettype none
module supply_guard
    import guard_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] uv_pins_i,
    output logic [3:0] uv_o,
    output logic uv_any_o
);
    logic [3:0] uv_meta_q;

    ////////////////////////////////////////////////////////////////////////
    // two-stage sync of bus, buffer, digital and analog undervoltage
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uv_meta_q <= UV_NONE;
            uv_o <= UV_NONE;
        end else begin
            uv_meta_q <= uv_pins_i;
            uv_o <= uv_meta_q;
        end
    end

    // any supply low triggers abort handling
    assign uv_any_o = |uv_o;
endmodule
`default_nettype wire

//--- verilog/register_guard_crc_supply_abort.sv
`timescale 1ns/1ps
`default_nettype none
module register_guard_crc_supply_abort
    import guard_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire proto_mode_t mode_i,
    input wire logic end_of_init_i,
    input wire logic cmd_valid_i,
    input wire reg_cmd_t cmd_i,
    input wire link_phase_t phase_i,
    input wire logic otp_load_i,
    input wire logic [7:0] otp_addr_i,
    input wire logic [7:0] otp_data_i,
    input wire logic [3:0] uv_pins_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic tx_abort_o,
    output logic period_suppress_o,
    output logic bdm_flush_o,
    output logic cap_test_o,
    output logic core_hold_o,
    output logic [7:0] status_word_one_o
);
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN = 2'b10
    } scan_state_t;

    logic [7:0] regs_q [256];
    logic [3:0] uv;
    logic uv_any;
    logic uv_any_q;
    logic discard_q;
    logic buffer_cap_fault_q;
    logic otp_crc_err_q;
    logic arr_crc_err_q;
    logic [3:0] cap_cnt_q;
    scan_state_t scan_q;
    logic [7:0] scan_addr_q;
    logic [3:0] blk_crc;
    logic [3:0] arr_crc;
    logic [3:0] arr_ref_q;
    logic arr_ref_ok_q;
    logic blk_clear;
    logic blk_en;
    logic blk_check;
    logic arr_en;
    logic arr_clear;
    logic arr_done_q;
    logic arr_fresh_q;
    logic cmd_in_map;
    logic cmd_writable;
    logic cmd_take;

    ////////////////////////////////////////////////////////////////////////
    // supply monitoring
    supply_guard u_supply (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .uv_pins_i(uv_pins_i),
        .uv_o(uv),
        .uv_any_o(uv_any)
    );

    // core hold while any supply is low
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_hold_o <= 1'b1;
            uv_any_q <= 1'b0;
        end else begin
            core_hold_o <= uv_any;
            uv_any_q <= uv_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address classification
    always_comb begin
        cmd_in_map = (cmd_i.addr == STATUS_WORD_ONE_ADDR) ||
                     (cmd_i.addr >= RW_LO && cmd_i.addr <= UF1_HI) ||
                     (cmd_i.addr >= FAC_LO);
        cmd_writable = (cmd_i.addr >= RW_LO && cmd_i.addr <= RW_HI) ||
                       (cmd_i.addr >= UF2_LO && cmd_i.addr < UF2_HI &&
                        !end_of_init_i);
        cmd_take = cmd_valid_i && !uv_any && !discard_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // discard a command whose reception met an undervoltage
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            discard_q <= 1'b0;
        end else if (uv_any && phase_i.rx_active) begin
            discard_q <= 1'b1;
        end else if (cmd_valid_i || (!phase_i.rx_active && !uv_any)) begin
            discard_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register array: otp load, command writes
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 256; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (otp_load_i && !end_of_init_i) begin
            regs_q[otp_addr_i] <= otp_data_i;
        end else if (cmd_take && cmd_i.write && cmd_in_map && cmd_writable) begin
            regs_q[cmd_i.addr] <= cmd_i.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response data
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_valid_o <= 1'b0;
            rsp_data_o <= ZERO_DATA;
        end else begin
            rsp_valid_o <= cmd_take;
            if (!cmd_take) begin
                rsp_data_o <= rsp_data_o;
            end else if (!cmd_in_map) begin
                rsp_data_o <= ZERO_DATA;
            end else if (cmd_i.addr == STATUS_WORD_ONE_ADDR) begin
                rsp_data_o <= status_word_one_o;
            end else if (cmd_i.write && cmd_writable) begin
                rsp_data_o <= cmd_i.data;
            end else begin
                rsp_data_o <= regs_q[cmd_i.addr];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // abort handling per protocol
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_abort_o <= 1'b0;
            period_suppress_o <= 1'b0;
            bdm_flush_o <= 1'b0;
        end else begin
            // response cut while supply low, never resent
            tx_abort_o <= uv_any && (phase_i.tx_active || phase_i.bdm_tx_active);
            // periodic slot dropped when reception is hit
            period_suppress_o <= uv_any && phase_i.rx_active &&
                                 (mode_i == MODE_PDCM);
            // partial diagnostic command flushed on new dip
            bdm_flush_o <= uv_any && !uv_any_q && (mode_i == MODE_PDCM);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer capacitor test at each transmission start
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_cnt_q <= 4'h0;
            cap_test_o <= 1'b0;
        end else if (phase_i.tx_start) begin
            cap_cnt_q <= CAP_TEST_CYC;
            cap_test_o <= 1'b1;
        end else if (cap_cnt_q != 4'h0) begin
            cap_cnt_q <= cap_cnt_q - 4'h1;
            cap_test_o <= (cap_cnt_q != 4'h1);
        end else begin
            cap_test_o <= 1'b0;
        end
    end

    // sticky capacitor fault
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buffer_cap_fault_q <= 1'b0;
        end else if (cap_test_o && uv[1]) begin
            buffer_cap_fault_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // background scan of all addresses, one byte per cycle
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scan_q <= SCAN_IDLE;
            scan_addr_q <= 8'h00;
        end else begin
            case (scan_q)
                SCAN_IDLE: begin
                    scan_q <= SCAN_RUN;
                    scan_addr_q <= 8'h00;
                end
                SCAN_RUN: begin
                    scan_addr_q <= scan_addr_q + 8'h01;
                end
                default: begin
                    scan_q <= SCAN_IDLE;
                end
            endcase
        end
    end

    // block crc feed and check points
    always_comb begin
        blk_en = (scan_q == SCAN_RUN) &&
                 ((scan_addr_q >= UF2_LO && scan_addr_q <= UF1_HI) ||
                  scan_addr_q >= FAC_LO) &&
                 (scan_addr_q[3:0] != BLOCK_LAST ||
                  scan_addr_q == UF2_MID - 8'h01);
        blk_clear = scan_addr_q[3:0] == 4'h0 && scan_addr_q != UF2_MID;
        blk_check = (scan_q == SCAN_RUN) && scan_addr_q[3:0] == BLOCK_LAST &&
                    ((scan_addr_q >= UF2_LO && scan_addr_q <= UF1_HI &&
                      scan_addr_q != UF2_MID - 8'h01) ||
                     scan_addr_q >= FAC_LO) &&
                    regs_q[scan_addr_q][LOCK_BIT];
        arr_en = (scan_q == SCAN_RUN) && end_of_init_i &&
                 scan_addr_q >= RW_LO && scan_addr_q <= UF2_HI &&
                 scan_addr_q != LOCK_WR_ADDR;
        arr_clear = scan_addr_q == 8'h00;
    end

    crc4_unit u_blk_crc (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(blk_clear),
        .en_i(blk_en),
        .byte_i(regs_q[scan_addr_q]),
        .crc_o(blk_crc)
    );

    crc4_unit u_arr_crc (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(arr_clear),
        .en_i(arr_en),
        .byte_i(regs_q[scan_addr_q]),
        .crc_o(arr_crc)
    );

    // stored block crc compare
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            otp_crc_err_q <= 1'b0;
        end else if (blk_check && blk_crc != regs_q[scan_addr_q][CRC_MSB:0]) begin
            otp_crc_err_q <= 1'b1;
        end
    end

    // array crc: first whole pass after init or a write is the reference
    // a pass cut by a write or by init rising must not become the reference
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arr_done_q <= 1'b0;
            arr_fresh_q <= 1'b0;
            arr_ref_q <= CRC_SEED;
            arr_ref_ok_q <= 1'b0;
            arr_crc_err_q <= 1'b0;
        end else begin
            arr_done_q <= arr_en && scan_addr_q == UF2_HI;
            if (arr_clear && end_of_init_i) begin
                arr_fresh_q <= 1'b1; // pass starts with settled contents
            end else if (!end_of_init_i || (cmd_take && cmd_i.write && cmd_writable)) begin
                arr_fresh_q <= 1'b0;
            end
            if (!end_of_init_i || (cmd_take && cmd_i.write && cmd_writable)) begin
                arr_ref_ok_q <= 1'b0; // legal write re-arms reference
            end else if (arr_done_q && !arr_ref_ok_q && arr_fresh_q) begin
                arr_ref_q <= arr_crc;
                arr_ref_ok_q <= 1'b1;
            end else if (arr_done_q && arr_ref_ok_q && arr_crc != arr_ref_q) begin
                arr_crc_err_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word one
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_word_one_o <= ZERO_DATA;
        end else begin
            status_word_one_o <= ZERO_DATA;
            status_word_one_o[ST_BUF_CAP] <= buffer_cap_fault_q;
            status_word_one_o[ST_OTP_CRC] <= otp_crc_err_q;
            status_word_one_o[ST_ARR_CRC] <= arr_crc_err_q;
        end
    end
endmodule
`default_nettype wire

//--- verification/guard_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module guard_asserts
    import guard_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire proto_mode_t mode_i,
    input wire logic end_of_init_i,
    input wire logic cmd_valid_i,
    input wire reg_cmd_t cmd_i,
    input wire link_phase_t phase_i,
    input wire logic otp_load_i,
    input wire logic [7:0] otp_addr_i,
    input wire logic [7:0] otp_data_i,
    input wire logic [3:0] uv_pins_i,
    input wire logic rsp_valid_o,
    input wire logic [7:0] rsp_data_o,
    input wire logic tx_abort_o,
    input wire logic period_suppress_o,
    input wire logic bdm_flush_o,
    input wire logic cap_test_o,
    input wire logic core_hold_o,
    input wire logic [7:0] status_word_one_o
);
    logic [2:0] quiet_q;
    logic taken;
    logic bad_addr;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////
    // cycles since supplies came good, with one idle reception slot
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quiet_q <= 3'h0;
        end else if (uv_pins_i != UV_NONE) begin
            quiet_q <= 3'h0;
        end else if (quiet_q != 3'h7 && (quiet_q != 3'h3 || !phase_i.rx_active)) begin
            quiet_q <= quiet_q + 3'h1;
        end
    end
    // a command that must be taken, and addresses outside the map
    assign taken = cmd_valid_i && quiet_q >= 3'h5;
    assign bad_addr = !(cmd_i.addr == STATUS_WORD_ONE_ADDR || cmd_i.addr >= FAC_LO ||
        (cmd_i.addr >= RW_LO && cmd_i.addr <= UF1_HI));
    sequence dip_in_tx;
        (uv_pins_i != UV_NONE && (phase_i.tx_active || phase_i.bdm_tx_active))[*4];
    endsequence
    sequence dip_in_rx;
        (uv_pins_i != UV_NONE && phase_i.rx_active && mode_i == MODE_PDCM)[*4];
    endsequence
    ////////////////////////////////////////
    rsp_taken_a: assert property (taken |=> rsp_valid_o)
        else $error("taken command not answered");
    rsp_cause_a: assert property (rsp_valid_o |-> $past(cmd_valid_i))
        else $error("answer without command");
    bad_zero_a: assert property (taken && bad_addr |=> rsp_data_o == ZERO_DATA)
        else $error("unmapped address answered nonzero");
    mirror_echo_a: assert property (taken && cmd_i.write && !end_of_init_i &&
        cmd_i.addr >= UF2_LO && cmd_i.addr < REGION3_LOCK_CRC_ADDR |=>
        rsp_data_o == $past(cmd_i.data)) else $error("mirror write not applied");
    uv_refuse_a: assert property ((uv_pins_i != UV_NONE)[*3] ##0 cmd_valid_i |=>
        !rsp_valid_o) else $error("command answered under low supply");
    hold_on_uv_a: assert property ((uv_pins_i != UV_NONE)[*3] |=> core_hold_o)
        else $error("core not held under low supply");
    abort_tx_a: assert property (dip_in_tx |-> tx_abort_o)
        else $error("response not cut under low supply");
    suppress_rx_a: assert property (dip_in_rx |-> period_suppress_o)
        else $error("period answer not suppressed");
    flush_once_a: assert property (bdm_flush_o |=> !bdm_flush_o)
        else $error("flush longer than one cycle");
    cap_window_a: assert property (phase_i.tx_start |=> cap_test_o[*8])
        else $error("capacitor test window short");
    errors_sticky_a: assert property (
        ($past(status_word_one_o[2:0]) & ~status_word_one_o[2:0]) == 3'h0)
        else $error("status error flag cleared");
endmodule
`default_nettype wire

//--- verification/guard_master.sv
`timescale 1ns/1ps
`default_nettype none
module guard_master
    import guard_pkg::*;
(
    input wire logic ref_clk_i,
    output logic cmd_valid_o,
    output reg_cmd_t cmd_o,
    output link_phase_t phase_o
);
    // idle bus at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
        phase_o = '0;
    end
    // wait n edges, then step just past the edge
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            #2;
        end
    endtask
    // reception, decoded command, then the answer slot
    task automatic send(input reg_cmd_t c, input int rx, input int tx, input bit bdm);
        if (rx > 0) begin
            phase_o.rx_active = 1'b1;
            tick(rx);
            phase_o.rx_active = 1'b0;
        end
        cmd_valid_o = 1'b1;
        cmd_o = c;
        tick(1);
        cmd_valid_o = 1'b0;
        cmd_o = ~c;  // stale command does not stand
        if (tx > 0) begin
            phase_o.tx_start = 1'b1;
            phase_o.tx_active = !bdm;
            phase_o.bdm_tx_active = bdm;
            tick(1);
            phase_o.tx_start = 1'b0;
            tick(tx - 1);
            phase_o.tx_active = 1'b0;
            phase_o.bdm_tx_active = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- verification/register_guard_crc_supply_abort_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module register_guard_crc_supply_abort_tb_top
    import guard_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic end_of_init_i = 1'b0;
    logic otp_load_i = 1'b0;
    logic [7:0] otp_addr_i = 8'h00;
    logic [7:0] otp_data_i = 8'h00;
    logic [3:0] uv_pins_i = 4'h0;
    proto_mode_t mode_i = MODE_CRM;
    logic cmd_valid_i;
    reg_cmd_t cmd_i;
    link_phase_t phase_i;
    logic rsp_valid_o, tx_abort_o, period_suppress_o, bdm_flush_o, cap_test_o, core_hold_o;
    logic [7:0] rsp_data_o, status_word_one_o;
    logic [7:0] exp_status = 8'h00;
    logic [7:0] mem [256] = '{default: 8'h00};
    logic [7:0] q [$];
    logic [3:0] seen = 4'h0;
    int errors = 0;
    int n_compared = 0;
    int seed = 32'h3a1c;
    logic [7:0] adr [12] = '{8'h02, 8'h05, 8'h10, 8'h3f, 8'h40, 8'h5e, 8'h5f, 8'h60, 8'h7f,
        8'h8a, 8'ha0, 8'hff};
    proto_mode_t mt [4] = '{MODE_CRM, MODE_PDCM, MODE_PSI5, MODE_PDCM};
    always #50 ref_clk_i = ~ref_clk_i;
    register_guard_crc_supply_abort u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .mode_i(mode_i), .end_of_init_i(end_of_init_i), .cmd_valid_i(cmd_valid_i),
        .cmd_i(cmd_i), .phase_i(phase_i), .otp_load_i(otp_load_i), .otp_addr_i(otp_addr_i),
        .otp_data_i(otp_data_i), .uv_pins_i(uv_pins_i), .rsp_valid_o(rsp_valid_o),
        .rsp_data_o(rsp_data_o), .tx_abort_o(tx_abort_o), .period_suppress_o(period_suppress_o),
        .bdm_flush_o(bdm_flush_o), .cap_test_o(cap_test_o), .core_hold_o(core_hold_o),
        .status_word_one_o(status_word_one_o));
    guard_master u_master (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i),
        .phase_o(phase_i));
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk_i);
            #2;
        end
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [3:0] crc(input logic [3:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h9 : 4'h0);
        return c;
    endfunction
    // expected answer, and register contents after a command
    function automatic logic [7:0] model(input reg_cmd_t c);
        logic ok;
        logic ro;
        ok = (c.addr >= RW_LO && c.addr <= RW_HI) ||
            (c.addr >= UF2_LO && c.addr < REGION3_LOCK_CRC_ADDR && !end_of_init_i);
        ro = (c.addr >= UF2_LO && c.addr <= UF1_HI) || c.addr >= FAC_LO;
        if (c.addr == STATUS_WORD_ONE_ADDR) return exp_status;
        if (!ok && !ro) return ZERO_DATA;
        if (c.write && ok) mem[c.addr] = c.data;
        return mem[c.addr];
    endfunction
    // load a block from otp; last byte is lock, id and block crc
    task automatic blk(input logic [7:0] b, input logic [7:0] l, input logic [2:0] id, input bit bad);
        logic [3:0] c;
        c = CRC_SEED;
        otp_load_i = 1'b1;
        for (int a = b; a <= l; a++) begin
            otp_addr_i = a[7:0];
            otp_data_i = (a == l) ? {1'b1, id, c ^ {3'h0, bad}} : 8'($random(seed));
            if (a < l) c = crc(c, otp_data_i);
            mem[a] = otp_data_i;
            tick(1);
        end
        otp_load_i = 1'b0;
    endtask
    task automatic send(input logic w, input logic [7:0] a, input int rx, input int tx,
        input bit bdm, input bit ok);
        reg_cmd_t c;
        c = '{w, a, 8'($random(seed))};
        if (ok) q.push_back(model(c));
        u_master.send(c, rx, tx, bdm);
    endtask
    // supply dip on pin p, k cycles into a read of 0x11
    task automatic dip(input logic [3:0] p, input int k, input int rx, input int tx,
        input bit bdm, input bit ok);
        seen = 4'h0;
        fork
            send(1'b0, 8'h11, rx, tx, bdm, ok);
            begin
                tick(k);
                uv_pins_i = p;
                tick(4);
                uv_pins_i = 4'h0;
            end
        join
        tick(10);
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        tick(12);
        rst_b_i = 1'b1;
        blk(UF2_LO, REGION3_LOCK_CRC_ADDR, 3'h0, 1'b0);
        blk(UF0_LO, 8'h6f, 3'h0, 1'b0);
        blk(8'h70, UF1_HI, 3'h0, 1'b0);
        blk(FAC_LO, 8'haf, 3'h1, 1'b0);
        tick(300);
        chk(status_word_one_o, 8'h00);
        otp_load_i = 1'b1;
        otp_addr_i = REGION3_LOCK_CRC_ADDR;
        otp_data_i = 8'h00;
        mem[REGION3_LOCK_CRC_ADDR] = 8'h00;
        tick(1);
        otp_load_i = 1'b0;
        for (int e = 0; e < 2; e++) begin
            end_of_init_i = e[0];
            foreach (adr[i]) begin
                send(1'b1, adr[i], 1, 2, 1'b0, 1'b1);
                send(1'b0, adr[i], 0, 2, 1'b0, 1'b1);
            end
        end
        tick(600);
        chk(status_word_one_o, 8'h00);
        end_of_init_i = 1'b0;
        blk(UF0_LO, 8'h6f, 3'h0, 1'b1);
        tick(300);
        exp_status = 8'h02;
        chk(status_word_one_o, exp_status);
        for (int i = 0; i < 4; i++) begin
            mode_i = mt[i];
            tick(2);
            dip(4'(4'h1 << i), 1, 6, 0, 1'b0, 1'b0);
            chk({4'h0, seen}, {5'h0, mt[i] == MODE_PDCM, mt[i] == MODE_PDCM, 1'b1});
            send(1'b0, 8'h11, 1, 2, 1'b0, 1'b1);
            dip(4'(4'h1 << i), 4, 2, 6, i == 3, 1'b1);
            chk({7'h0, seen[3]}, 8'h01);
        end
        exp_status = 8'h03;
        chk(status_word_one_o, exp_status);
        send(1'b0, STATUS_WORD_ONE_ADDR, 1, 2, 1'b0, 1'b1);
        tick(5);
        chk(8'(q.size()), 8'h00);
        complete_run();
    end
    // watch outputs; each answer takes the oldest expectation
    always @(negedge ref_clk_i) begin
        seen = seen | {tx_abort_o === 1'b1, period_suppress_o === 1'b1, bdm_flush_o === 1'b1,
            core_hold_o === 1'b1};
        if (rsp_valid_o === 1'b1) chk(rsp_data_o, q.size() ? q.pop_front() : 8'hxx);
    end
    // hang guard
    initial begin
        tick(20000);
        errors++;
        complete_run();
    end
endmodule
bind register_guard_crc_supply_abort guard_asserts u_chk (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .mode_i(mode_i), .end_of_init_i(end_of_init_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .phase_i(phase_i), .otp_load_i(otp_load_i),
    .otp_addr_i(otp_addr_i), .otp_data_i(otp_data_i), .uv_pins_i(uv_pins_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .tx_abort_o(tx_abort_o),
    .period_suppress_o(period_suppress_o), .bdm_flush_o(bdm_flush_o),
    .cap_test_o(cap_test_o), .core_hold_o(core_hold_o),
    .status_word_one_o(status_word_one_o));
`default_nettype wire
